/* File: core/dct_pkg.sv */
// constants shared by the completion and turnaround block
package dct_pkg;
	// ********************************
	// register map (byte addresses)
	// ********************************
	localparam int DCT_AW = 8;
	localparam int DCT_DW = 32;
	localparam logic [DCT_AW-1:0] DCT_OFS_CTRL = 8'h00;
	localparam logic [DCT_AW-1:0] DCT_OFS_TURN = 8'h04;
	localparam logic [DCT_AW-1:0] DCT_OFS_STAT = 8'h08;
	localparam logic [DCT_AW-1:0] DCT_OFS_MASK = 8'h0c;
	localparam logic [DCT_AW-1:0] DCT_OFS_STATE = 8'h10;
	// ********************************
	// reset values and timing
	// ********************************
	localparam int DCT_TURN_W = 4;
	localparam logic [DCT_TURN_W-1:0] DCT_TURN_RST = 4'h2;
	localparam int DCT_CLK_MHZ = 50;
	localparam int DCT_DESC_GAP_CLKS = 2;
	localparam int DCT_SYNC_STAGES = 2;
	// state register field positions
	localparam int DCT_ST_CNT_LSB = 0;
	localparam int DCT_ST_DESC_BIT = 8;
	localparam int DCT_ST_PEND_LSB = 16;
endpackage

/* File: core/dct_sync.sv */
// two-stage level synchronizer
`timescale 1ns/100ps
`default_nettype none
module dct_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rstN,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = din;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule // dct_sync
`default_nettype wire

/* File: core/dct_top.sv */
// dma completion and bus turnaround control
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1 - hold a dma write in the read-end cycle, and after a read while turnaround clocks are still short
// RL2 - after a descriptor burst read no turnaround clocks are added
// RL3 - external active-low stop request is synchronized and held pending
// RL4 - pending stop: after current transfer, clear enable unless ctrl is written in that cycle, raise stop interrupt
// RL5 - stop interrupt still raised when channel completes or disables same cycle
// RL6 - pending stop is cleared when software enables the channel again
// RL7 - raise fully-disabled interrupt once channel is done and its fifo is empty
// RL8 - count idle clocks since last read end, compare with turnaround value
module dct_top import dct_pkg::*; #(
	parameter int NCH = 2,
	parameter int CNT_W = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [DCT_AW-1:0] regAddr,
	input wire logic [DCT_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DCT_DW-1:0] regRdData,
	input wire logic dmaRdEnd,
	input wire logic dmaRdDesc,
	input wire logic dmaWrReq,
	output logic dmaWrGo,
	input wire logic [NCH-1:0] dmaDoneN,
	input wire logic [NCH-1:0] chBusy,
	input wire logic [NCH-1:0] chComplete,
	input wire logic [NCH-1:0] fifoEmpty,
	output logic [NCH-1:0] chEnable,
	output logic irq
);
	// ********************************
	// elaboration checks
	// ********************************
	if (2 * NCH > DCT_DW || NCH > DCT_ST_PEND_LSB || NCH < 1) begin : g_bad_nch
		$error("NCH out of range");
	end
	if (CNT_W < DCT_TURN_W || CNT_W > DCT_ST_DESC_BIT) begin : g_bad_cnt
		$error("CNT_W out of range");
	end
	if (DCT_SYNC_STAGES != 2) begin : g_bad_sync
		$error("synchronizer is fixed at two stages");
	end

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	// ********************************
	// reset release
	// ********************************
	logic rstMeta_ff;
	logic rstN;
	logic nxt_rstMeta;
	logic nxt_rstN;

	always_comb begin
		nxt_rstMeta = 1'b1;
		nxt_rstN = rstMeta_ff;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_ff <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta_ff <= nxt_rstMeta;
			rstN <= nxt_rstN;
		end
	end

	// ********************************
	// stop request synchronizer
	// ********************************
	logic [NCH-1:0] stopSync;
	dct_sync #(.W(NCH)) u_sync (
		.ref_clk(ref_clk),
		.rstN(rstN),
		.din(~dmaDoneN),
		.dout(stopSync)
	);

	// ********************************
	// register bus decode
	// ********************************
	logic wrCtrl;
	logic wrTurn;
	logic wrStat;
	logic wrMask;
	assign wrCtrl = regWr && (regAddr == DCT_OFS_CTRL);
	assign wrTurn = regWr && (regAddr == DCT_OFS_TURN);
	assign wrStat = regWr && (regAddr == DCT_OFS_STAT);
	assign wrMask = regWr && (regAddr == DCT_OFS_MASK);

	// ********************************
	// turnaround tracking
	// ********************************
	logic [CNT_W-1:0] idleCnt_ff;
	logic [CNT_W-1:0] nxt_idleCnt;
	logic lastDesc_ff;
	logic nxt_lastDesc;
	logic [DCT_TURN_W-1:0] turn_ff;
	logic [DCT_TURN_W-1:0] nxt_turn;
	logic dmaWrGo_ff;
	logic nxt_dmaWrGo;
	logic wrOk;

	// idle clocks already meet the programmed gap, or last read was a descriptor
	assign wrOk = lastDesc_ff || (idleCnt_ff >= CNT_W'(turn_ff)); // RL1 RL2 RL8

	always_comb begin
		nxt_idleCnt = idleCnt_ff;
		nxt_lastDesc = lastDesc_ff;
		nxt_turn = turn_ff;
		if (dmaRdEnd) begin
			nxt_idleCnt = '0; // RL8
			nxt_lastDesc = dmaRdDesc; // RL2
		end else if (idleCnt_ff != CNT_MAX) begin
			nxt_idleCnt = idleCnt_ff + 1'b1; // RL8
		end
		if (wrTurn) begin
			nxt_turn = regWrData[DCT_TURN_W-1:0];
		end
		nxt_dmaWrGo = dmaWrReq && wrOk && !dmaRdEnd; // RL1
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			idleCnt_ff <= CNT_MAX;
			lastDesc_ff <= 1'b0;
			turn_ff <= DCT_TURN_RST;
			dmaWrGo_ff <= 1'b0;
		end else begin
			idleCnt_ff <= nxt_idleCnt;
			lastDesc_ff <= nxt_lastDesc;
			turn_ff <= nxt_turn;
			dmaWrGo_ff <= nxt_dmaWrGo;
		end
	end

	// ********************************
	// channel completion
	// ********************************
	logic [NCH-1:0] chEn_ff;
	logic [NCH-1:0] nxt_chEn;
	logic [NCH-1:0] pend_ff;
	logic [NCH-1:0] nxt_pend;
	logic [NCH-1:0] taken_ff;
	logic [NCH-1:0] nxt_taken;
	logic [NCH-1:0] armed_ff;
	logic [NCH-1:0] nxt_armed;
	logic [NCH-1:0] reEn;
	logic [NCH-1:0] fireStop;
	logic [NCH-1:0] fireOff;

	assign reEn = wrCtrl ? (regWrData[NCH-1:0] & ~chEn_ff) : '0;
	// stop fires once per enable, when no transfer is in flight
	assign fireStop = pend_ff & ~taken_ff & ~chBusy; // RL4 RL5
	assign fireOff = armed_ff & ~chEn_ff & ~chBusy & fifoEmpty; // RL7

	always_comb begin
		nxt_chEn = chEn_ff & ~chComplete & ~fireStop; // RL4
		if (wrCtrl) begin
			nxt_chEn = regWrData[NCH-1:0];
		end
		nxt_pend = (pend_ff & ~reEn) | stopSync; // RL3 RL6
		nxt_taken = (taken_ff | fireStop) & ~reEn; // RL6
		nxt_armed = (armed_ff & ~fireOff) | reEn; // RL7
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			chEn_ff <= '0;
			pend_ff <= '0;
			taken_ff <= '0;
			armed_ff <= '0;
		end else begin
			chEn_ff <= nxt_chEn;
			pend_ff <= nxt_pend;
			taken_ff <= nxt_taken;
			armed_ff <= nxt_armed;
		end
	end

	// ********************************
	// interrupt status and mask
	// ********************************
	logic [2*NCH-1:0] stat_ff;
	logic [2*NCH-1:0] nxt_stat;
	logic [2*NCH-1:0] mask_ff;
	logic [2*NCH-1:0] nxt_mask;
	logic irq_ff;
	logic nxt_irq;

	always_comb begin
		nxt_stat = stat_ff;
		if (wrStat) begin
			nxt_stat = stat_ff & ~regWrData[2*NCH-1:0];
		end
		// a new event wins over a clear in the same cycle
		nxt_stat = nxt_stat | {fireOff, fireStop}; // RL4 RL5 RL7
		nxt_mask = wrMask ? regWrData[2*NCH-1:0] : mask_ff;
		nxt_irq = |(stat_ff & mask_ff);
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			stat_ff <= '0;
			mask_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
		end
	end

	// ********************************
	// read data
	// ********************************
	logic [DCT_DW-1:0] rdData_ff;
	logic [DCT_DW-1:0] nxt_rdData;

	always_comb begin
		nxt_rdData = '0;
		if (regRd) begin
			unique case (regAddr)
				DCT_OFS_CTRL: nxt_rdData[NCH-1:0] = chEn_ff;
				DCT_OFS_TURN: nxt_rdData[DCT_TURN_W-1:0] = turn_ff;
				DCT_OFS_STAT: nxt_rdData[2*NCH-1:0] = stat_ff;
				DCT_OFS_MASK: nxt_rdData[2*NCH-1:0] = mask_ff;
				DCT_OFS_STATE: begin
					nxt_rdData[DCT_ST_CNT_LSB +: CNT_W] = idleCnt_ff;
					nxt_rdData[DCT_ST_DESC_BIT] = lastDesc_ff;
					nxt_rdData[DCT_ST_PEND_LSB +: NCH] = pend_ff;
				end
				default: nxt_rdData = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rdData_ff <= '0;
		end else begin
			rdData_ff <= nxt_rdData;
		end
	end

	assign regRdData = rdData_ff;
	assign dmaWrGo = dmaWrGo_ff;
	assign chEnable = chEn_ff;
	assign irq = irq_ff;

	// ********************************
	// checks
	// ********************************
	chk_wr_held: assert property (@(posedge ref_clk) disable iff (!rstN) // RL1
		(dmaWrReq && !lastDesc_ff && (idleCnt_ff < CNT_W'(turn_ff))) |=> !dmaWrGo_ff)
		else $error("write started inside turnaround gap");
	chk_wr_free: assert property (@(posedge ref_clk) disable iff (!rstN) // RL8
		(dmaWrReq && !dmaRdEnd && (idleCnt_ff >= CNT_W'(turn_ff))) |=> dmaWrGo_ff)
		else $error("write held although gap met");
	chk_desc_nogap: assert property (@(posedge ref_clk) disable iff (!rstN) // RL2
		(dmaRdEnd && dmaRdDesc) ##1 (dmaWrReq && !dmaRdEnd) |=> dmaWrGo_ff)
		else $error("turnaround added after descriptor read");
	chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rstN)
		##1 irq_ff == |($past(stat_ff) & $past(mask_ff)))
		else $error("interrupt output wrong");
	chk_rd_idle: assert property (@(posedge ref_clk) disable iff (!rstN)
		!regRd |=> (rdData_ff == '0))
		else $error("read data not zero outside read cycle");
	chk_gap_restart: assert property (@(posedge ref_clk) disable iff (!rstN) // RL8
		dmaRdEnd |=> (idleCnt_ff == '0))
		else $error("idle count not restarted after read");

	for (genvar i = 0; i < NCH; i++) begin : g_chk
		chk_stop_held: assert property (@(posedge ref_clk) disable iff (!rstN) // RL3
			(stopSync[i] || (pend_ff[i] && !reEn[i])) |=> pend_ff[i])
			else $error("stop request lost");
		chk_stop_fire: assert property (@(posedge ref_clk) disable iff (!rstN) // RL4
			(pend_ff[i] && !taken_ff[i] && !chBusy[i] && !wrCtrl) |=> (!chEn_ff[i] && stat_ff[i]))
			else $error("stop not completed");
		chk_stop_race: assert property (@(posedge ref_clk) disable iff (!rstN) // RL5
			(fireStop[i] && (chComplete[i] || wrStat)) |=> stat_ff[i])
			else $error("stop interrupt dropped");
		chk_pend_clear: assert property (@(posedge ref_clk) disable iff (!rstN) // RL6
			(reEn[i] && !stopSync[i]) |=> !pend_ff[i])
			else $error("pending stop not cleared");
		chk_off_irq: assert property (@(posedge ref_clk) disable iff (!rstN) // RL7
			(armed_ff[i] && !chEn_ff[i] && !chBusy[i] && fifoEmpty[i]) |=> stat_ff[NCH+i])
			else $error("disabled interrupt missing");
		chk_stop_after: assert property (@(posedge ref_clk) disable iff (!rstN) // RL4
			$rose(stat_ff[i]) |-> ($past(pend_ff[i]) && !$past(chBusy[i])))
			else $error("stop interrupt before transfer finished");
		chk_off_after: assert property (@(posedge ref_clk) disable iff (!rstN) // RL7
			$rose(stat_ff[NCH+i]) |->
			($past(fifoEmpty[i]) && !$past(chBusy[i]) && !$past(chEn_ff[i])))
			else $error("disabled interrupt before fifo empty");
	end
endmodule // dct_top
`default_nettype wire

/* File: verif/dct_mem_model.sv */
// dma read/write engine model facing the turnaround control
`timescale 1ns/100ps
`default_nettype none
module dct_mem_model (
	input wire logic ref_clk,
	input wire logic start,
	input wire logic desc,
	input wire logic dmaWrGo,
	output logic dmaRdEnd,
	output logic dmaRdDesc,
	output logic dmaWrReq,
	output logic done,
	output logic [7:0] gap
);
	// ************
	// read end, then a write held until granted
	// ************
	initial begin
		{dmaRdEnd, dmaRdDesc, dmaWrReq, done, gap} = '0;
	end
	always @(posedge ref_clk) begin
		dmaRdEnd <= start;
		// qualifier means nothing outside read end, so it toggles
		dmaRdDesc <= start ? desc : ~dmaRdDesc;
		if (start) begin
			gap <= 8'h00;
			done <= 1'b0;
		end else if (dmaWrReq && dmaWrGo) begin
			dmaWrReq <= 1'b0;
			done <= 1'b1;
		end else if (dmaRdEnd || dmaWrReq) begin
			dmaWrReq <= 1'b1;
			gap <= gap + 8'h01;
		end
	end
endmodule // dct_mem_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for completion and turnaround control
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb import dct_pkg::*;;
	logic ref_clk, nrst, regWr, regRd, start, desc, dmaRdEnd, dmaRdDesc, dmaWrReq, dmaWrGo;
	logic done, irq;
	logic [DCT_AW-1:0] regAddr;
	logic [DCT_DW-1:0] regWrData, regRdData, d;
	logic [1:0] dmaDoneN, chBusy, chComplete, fifoEmpty, chEnable;
	logic [7:0] gap;
	int n_fail, checks, i, t;
	dct_top dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dmaRdEnd(dmaRdEnd),
		.dmaRdDesc(dmaRdDesc), .dmaWrReq(dmaWrReq), .dmaWrGo(dmaWrGo), .dmaDoneN(dmaDoneN),
		.chBusy(chBusy), .chComplete(chComplete), .fifoEmpty(fifoEmpty),
		.chEnable(chEnable), .irq(irq));
	dct_mem_model mem (.ref_clk(ref_clk), .start(start), .desc(desc), .dmaWrGo(dmaWrGo),
		.dmaRdEnd(dmaRdEnd), .dmaRdDesc(dmaRdDesc), .dmaWrReq(dmaWrReq), .done(done),
		.gap(gap));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ************
	// bus tasks
	// ************
	task test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		d = regRdData & m;
		`CHK(d, e)
	endtask
	task xfer(input logic dsc, input logic [7:0] e);
		@(posedge ref_clk);
		start <= 1'b1;
		desc <= dsc;
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
		for (i = 0; i < 40 && done !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (done !== 1'b1) begin
			n_fail++;
			test_done;
		end
		`CHK(gap, e)
	endtask
	// ************
	// main sequence
	// ************
	initial begin
		{nrst, regWr, regRd, start, desc, chComplete, fifoEmpty} = '0;
		regAddr = '0;
		regWrData = '0;
		dmaDoneN = 2'b11;
		chBusy = 2'b01;
		n_fail = 0;
		checks = 0;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(DCT_OFS_TURN, 32'hf, {28'h0, DCT_TURN_RST});
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 32'hffffffff, 32'h0);
		$display("test regs done");
		wr(DCT_OFS_TURN, 32'h5);
		xfer(1'b1, 8'd2);
		for (t = 0; t < 16; t += 5) begin
			wr(DCT_OFS_TURN, t);
			xfer(1'b0, 8'(t + 2));
		end
		$display("test turnaround done");
		wr(DCT_OFS_MASK, 32'hf);
		wr(DCT_OFS_CTRL, 32'h1);
		@(posedge ref_clk);
		dmaDoneN <= 2'b10;
		repeat (2) @(posedge ref_clk);
		dmaDoneN <= 2'b11;
		repeat (4) @(posedge ref_clk);
		rd(DCT_OFS_STATE, 32'h10000, 32'h10000);
		`CHK(chEnable[0], 1'b1)
		@(posedge ref_clk);
		chBusy <= 2'b00;
		chComplete <= 2'b01;
		@(posedge ref_clk);
		chComplete <= 2'b00;
		for (i = 0; i < 20 && chEnable[0] !== 1'b0; i++) @(posedge ref_clk);
		`CHK(chEnable[0], 1'b0)
		rd(DCT_OFS_STAT, 32'h5, 32'h1);
		@(posedge ref_clk);
		fifoEmpty <= 2'b11;
		rd(DCT_OFS_STAT, 32'h5, 32'h5);
		`CHK(irq, 1'b1)
		wr(DCT_OFS_MASK, 32'h0);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wr(DCT_OFS_STAT, 32'h5);
		wr(DCT_OFS_MASK, 32'hf);
		rd(DCT_OFS_STAT, 32'h5, 32'h0);
		`CHK(irq, 1'b0)
		wr(DCT_OFS_CTRL, 32'h1);
		rd(DCT_OFS_STATE, 32'h10000, 32'h0);
		`CHK(chEnable[0], 1'b1)
		$display("test stop done");
		test_done;
	end
endmodule // tb
`default_nettype wire
